// >>> pwc_top.v
// Port 5/6/8 pad control, interrupt masks and port-6 change wake.
// Assumes the core issues single-cycle register reads and writes,
// and one-cycle pulses for the global on/off and sleep instructions.
`timescale 1ns/100ps
`include "pwc_map.vh"
module pwc_top (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    input  wire        dir_sel,
    output reg  [7:0]  reg_rdata,
    input  wire        global_irq_on_instr,
    input  wire        global_irq_off_instr,
    input  wire        sleep_instr,
    input  wire        timer8_flag,
    input  wire        ext_pin_flag,
    input  wire        converter_done_flag,
    input  wire        comparator2_change_flag,
    input  wire        timer3_flag,
    input  wire        input_change_clr,
    output wire        input_change_flag,
    output wire        irq_req,
    output wire [11:0] irq_vector,
    output wire        asleep,
    output reg         wake_pulse,
    output reg         wake_to_vector,
    input  wire [7:0]  port5_in,
    output wire [7:0]  port5_out,
    output wire [7:0]  port5_oe,
    output wire        port5_pull_down_en,
    input  wire [7:0]  port6_in,
    output wire [7:0]  port6_out,
    output wire [7:0]  port6_oe,
    output wire [5:0]  port6_pull_up_en,
    output wire [3:0]  port6_pull_down_en,
    input  wire [7:0]  port8_in,
    output wire [7:0]  port8_out,
    output wire [7:0]  port8_oe
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] pull_down_control_q;
    reg [7:0] open_drain_control_q;
    reg [7:0] pull_high_control_q;
    reg [7:0] interrupt_mask_second_q;
    reg [7:0] interrupt_mask_first_q;
    reg [7:0] port5_direction_q;
    reg [7:0] port6_direction_q;
    reg [7:0] port8_direction_q;
    reg [7:0] port5_data_q;
    reg [7:0] port6_data_q;
    reg [7:0] port8_data_q;
    reg [7:0] wake_ctl_q;
    reg [7:0] p6_ref_q;
    reg       chg_flag_q;
    reg       global_en_q;
    reg       asleep_q;

    wire [7:0] p5_s;
    wire [7:0] p6_s;
    wire [7:0] p8_s;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    pwc_sync #(.W(24)) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({port8_in, port6_in, port5_in}),
        .sync_out ({p8_s, p6_s, p5_s})
    );

    wire wr_ctl  = reg_wr & ~dir_sel;
    wire wr_dir  = reg_wr & dir_sel;
    wire rd_p6   = reg_rd & ~dir_sel & (reg_addr == `PWC_ADR_P6_DATA);
    wire chg_now = |(p6_s ^ p6_ref_q);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_down_control_q     <= `PWC_RST_PD;
            open_drain_control_q    <= `PWC_RST_OD;
            pull_high_control_q     <= `PWC_RST_PH;
            interrupt_mask_second_q <= `PWC_RST_MASK;
            interrupt_mask_first_q  <= `PWC_RST_MASK;
            port5_direction_q       <= `PWC_RST_DIR;
            port6_direction_q       <= `PWC_RST_DIR;
            port8_direction_q       <= `PWC_RST_DIR;
            port5_data_q            <= 8'h00;
            port6_data_q            <= 8'h00;
            port8_data_q            <= 8'h00;
            wake_ctl_q              <= 8'h00;
        end else if (wr_dir) begin
            case (reg_addr)
                `PWC_ADR_P5_DATA: port5_direction_q <= reg_wdata;
                `PWC_ADR_P6_DATA: port6_direction_q <= reg_wdata;
                `PWC_ADR_P8_DATA: port8_direction_q <= reg_wdata;
                `PWC_ADR_PULLDOWN: pull_down_control_q <=
                    reg_wdata & `PWC_PD_USED;
                `PWC_ADR_OPENDRN: open_drain_control_q <=
                    reg_wdata & `PWC_OD_USED;
                `PWC_ADR_PULLHIGH: pull_high_control_q <=
                    reg_wdata & `PWC_PH_USED;
                `PWC_ADR_MASK2: interrupt_mask_second_q <=
                    reg_wdata & `PWC_M2_USED;
                `PWC_ADR_MASK1: interrupt_mask_first_q <=
                    reg_wdata & `PWC_M1_USED;
                default: ;
            endcase
        end else if (wr_ctl) begin
            case (reg_addr)
                `PWC_ADR_P5_DATA:  port5_data_q <= reg_wdata;
                `PWC_ADR_P6_DATA:  port6_data_q <= reg_wdata;
                `PWC_ADR_P8_DATA:  port8_data_q <= reg_wdata;
                `PWC_ADR_WAKE_CTL: wake_ctl_q   <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always @* begin
        reg_rdata = 8'h00;
        if (dir_sel) begin
            case (reg_addr)
                `PWC_ADR_P5_DATA:  reg_rdata = port5_direction_q;
                `PWC_ADR_P6_DATA:  reg_rdata = port6_direction_q;
                `PWC_ADR_P8_DATA:  reg_rdata = port8_direction_q;
                `PWC_ADR_PULLDOWN: reg_rdata = pull_down_control_q;
                `PWC_ADR_OPENDRN:  reg_rdata = open_drain_control_q;
                `PWC_ADR_PULLHIGH: reg_rdata = pull_high_control_q;
                `PWC_ADR_MASK2:    reg_rdata = interrupt_mask_second_q;
                `PWC_ADR_MASK1:    reg_rdata = interrupt_mask_first_q;
                default:           reg_rdata = 8'h00;
            endcase
        end else begin
            case (reg_addr)
                `PWC_ADR_P5_DATA:  reg_rdata = p5_s;
                `PWC_ADR_P6_DATA:  reg_rdata = p6_s;
                `PWC_ADR_P8_DATA:  reg_rdata = p8_s;
                `PWC_ADR_WAKE_CTL: reg_rdata = wake_ctl_q;
                default:           reg_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Change detect, global enable, sleep
    // ------------------------------------------------------------
    wire chg_ie  = interrupt_mask_first_q[`PWC_M1_CHG];
    wire wake_ok = wake_ctl_q[`PWC_WAKE_CHG] & chg_now;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p6_ref_q       <= 8'h00;
            chg_flag_q     <= 1'b0;
            global_en_q    <= 1'b0;
            asleep_q       <= 1'b0;
            wake_pulse     <= 1'b0;
            wake_to_vector <= 1'b0;
        end else begin
            if (rd_p6)
                p6_ref_q <= p6_s;
            // Set beats clear so no edge is lost
            if (chg_now & ~rd_p6)
                chg_flag_q <= 1'b1;
            else if (input_change_clr)
                chg_flag_q <= 1'b0;
            if (global_irq_on_instr)
                global_en_q <= 1'b1;
            else if (global_irq_off_instr)
                global_en_q <= 1'b0;
            wake_pulse     <= 1'b0;
            wake_to_vector <= 1'b0;
            if (sleep_instr)
                asleep_q <= 1'b1;
            else if (asleep_q & wake_ok) begin
                asleep_q       <= 1'b0;
                wake_pulse     <= 1'b1;
                wake_to_vector <= chg_ie & global_en_q;
            end
        end
    end

    wire [7:0] pend = {comparator2_change_flag &
                       interrupt_mask_second_q[`PWC_M2_CMP2],
                       converter_done_flag &
                       interrupt_mask_first_q[`PWC_M1_ADC],
                       timer3_flag & interrupt_mask_second_q[`PWC_M2_TMR3],
                       3'b000,
                       ext_pin_flag & interrupt_mask_first_q[`PWC_M1_EXT],
                       timer8_flag & interrupt_mask_first_q[`PWC_M1_TMR8]};
    wire chg_pend = chg_flag_q & chg_ie;

    assign irq_req = global_en_q & ~asleep_q & (chg_pend | (|pend));
    assign irq_vector = `PWC_VEC_CHANGE;
    assign input_change_flag = chg_flag_q;
    assign asleep = asleep_q;

    // ------------------------------------------------------------
    // Pads
    // ------------------------------------------------------------
    wire [7:0] p5_pd;
    wire [7:0] p6_pu;
    wire [7:0] p6_pd;

    pwc_pad #(.W(8)) u_p5 (
        .out_data     (port5_data_q),
        .dir_in       (port5_direction_q),
        .od_en        (8'h00),
        .pu_off       (8'hFF),
        .pd_off       ({7'h7F, pull_down_control_q[0]}),
        .pad_out      (port5_out),
        .pad_oe       (port5_oe),
        .pull_up_en   (),
        .pull_down_en (p5_pd)
    );
    pwc_pad #(.W(8)) u_p6 (
        .out_data     (port6_data_q),
        .dir_in       (port6_direction_q),
        .od_en        (open_drain_control_q),
        .pu_off       ({2'b11, pull_high_control_q[5:0]}),
        .pd_off       ({4'hF, pull_down_control_q[7:4]}),
        .pad_out      (port6_out),
        .pad_oe       (port6_oe),
        .pull_up_en   (p6_pu),
        .pull_down_en (p6_pd)
    );
    pwc_pad #(.W(8)) u_p8 (
        .out_data     (port8_data_q),
        .dir_in       (port8_direction_q),
        .od_en        (8'h00),
        .pu_off       (8'hFF),
        .pd_off       (8'hFF),
        .pad_out      (port8_out),
        .pad_oe       (port8_oe),
        .pull_up_en   (),
        .pull_down_en ()
    );
    assign port5_pull_down_en = p5_pd[0];
    assign port6_pull_up_en   = p6_pu[5:0];
    assign port6_pull_down_en = p6_pd[3:0];
endmodule

// >>> pwc_map.vh
// Register addresses, field positions, reset values and vectors
// for the port pad control and change-wake block.
// Assumes the core presents an 8-bit control-register access port.
// Function
// - Active-low pull-down bits for port 6 and port 5
// - Open-drain enable bits for port-6 pins 5..0
// - Active-low pull-high bits for port-6 pins 5..0
// - Mask two: bit7 comparator2, bit5 timer3 enables
// - Mask one bit6 enables converter-done flag
// - Mask one bits 2,1,0: ext, change, timer8
// - Request needs mask bit and global enable
// - Unused bits read as zero, except in the wake-control register
// - All control registers readable and writable
// - Ports 5, 6, 8 per-pin tri-state direction
// - Direction 1 is input high-z, 0 output
// - Port-6 change sets flag, interrupts, wakes
// - Wake enable plus sleep; change then wakes
// - Enabled change interrupt vectors to address 006H
// - Masked change wake resumes after sleep
// - Reset: pull and direction regs ones, others zero
`ifndef PWC_MAP_VH
`define PWC_MAP_VH

// ----------------------------------------------------------------
// Control-register addresses
// ----------------------------------------------------------------
`define PWC_ADR_P5_DATA   4'h5
`define PWC_ADR_P6_DATA   4'h6
`define PWC_ADR_P8_DATA   4'h8
`define PWC_ADR_WAKE_CTL  4'hA
`define PWC_ADR_PULLDOWN  4'hB
`define PWC_ADR_OPENDRN   4'hC
`define PWC_ADR_PULLHIGH  4'hD
`define PWC_ADR_MASK2     4'hE
`define PWC_ADR_MASK1     4'hF

// ----------------------------------------------------------------
// Field layout and implemented-bit masks
// ----------------------------------------------------------------
`define PWC_PD_USED       8'hF1
`define PWC_OD_USED       8'h3F
`define PWC_PH_USED       8'h3F
`define PWC_M2_USED       8'hA0
`define PWC_M1_USED       8'h47
`define PWC_M2_CMP2       7
`define PWC_M2_TMR3       5
`define PWC_M1_ADC        6
`define PWC_M1_EXT        2
`define PWC_M1_CHG        1
`define PWC_M1_TMR8       0
`define PWC_WAKE_CHG      6

// ----------------------------------------------------------------
// Reset values and vectors
// ----------------------------------------------------------------
`define PWC_RST_PD        8'hF1
`define PWC_RST_OD        8'h00
`define PWC_RST_PH        8'h3F
`define PWC_RST_MASK      8'h00
`define PWC_RST_DIR       8'hFF
`define PWC_VEC_CHANGE    12'h006

`endif

// >>> pwc_sync.v
// Two-flop level synchroniser, one per bit.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/100ps
module pwc_sync #(
    parameter W = 8
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// >>> pwc_pad.v
// Per-pin pad control: direction, open-drain, pulls.
// Assumes control bits arrive from registers on the same clock.
`timescale 1ns/100ps
module pwc_pad #(
    parameter W = 8
) (
    input  wire [W-1:0] out_data,
    input  wire [W-1:0] dir_in,
    input  wire [W-1:0] od_en,
    input  wire [W-1:0] pu_off,
    input  wire [W-1:0] pd_off,
    output wire [W-1:0] pad_out,
    output wire [W-1:0] pad_oe,
    output wire [W-1:0] pull_up_en,
    output wire [W-1:0] pull_down_en
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_pin
            // Open-drain never drives high
            assign pad_oe[i] = ~dir_in[i] &
                               ~(od_en[i] & out_data[i]);
            assign pad_out[i] = od_en[i] ? 1'b0 : out_data[i];
            assign pull_up_en[i]   = ~pu_off[i];
            assign pull_down_en[i] = ~pd_off[i];
        end
    endgenerate
endmodule

// >>> pwc_pins.sv
// Board model for one port: pad drive, outside drivers, pulls.
// Assumes a pin that nobody drives or pulls keeps changing.
`timescale 1ns/100ps
module pwc_pins #(
    parameter W = 8
) (
    input  wire  [W-1:0] clk,
    input  wire  [W-1:0] oe,
    input  wire  [W-1:0] dout,
    input  wire  [W-1:0] ext_en,
    input  wire  [W-1:0] ext_val,
    input  wire  [W-1:0] pu,
    input  wire  [W-1:0] pd,
    output logic [W-1:0] pin
);
    logic [W-1:0] last;
    always @(posedge clk[0]) last <= pin;
    // Floating pins toggle so an unknown never settles by chance
    always @* begin
        for (int i = 0; i < W; i++)
            pin[i] = oe[i] ? dout[i] : ext_en[i] ? ext_val[i] :
                     pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~last[i];
    end
endmodule

// >>> pwc_top_sva.sv
// Checker for pwc_top: pads, masks, interrupt request and wake.
// Assumes the global on and off pulses never coincide.
`timescale 1ns/100ps
module pwc_top_sva (
    input wire       ref_clk,
    input wire       rst_n,
    input wire [3:0] reg_addr,
    input wire       reg_wr,
    input wire       dir_sel,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       global_irq_on_instr,
    input wire       global_irq_off_instr,
    input wire       sleep_instr,
    input wire       timer8_flag,
    input wire       ext_pin_flag,
    input wire       converter_done_flag,
    input wire       comparator2_change_flag,
    input wire       timer3_flag,
    input wire       input_change_flag,
    input wire       irq_req,
    input wire       asleep,
    input wire       wake_pulse,
    input wire       wake_to_vector,
    input wire       port5_pull_down_en,
    input wire [7:0] port6_out,
    input wire [7:0] port6_oe,
    input wire [5:0] port6_pull_up_en,
    input wire [3:0] port6_pull_down_en
);
    logic [7:0] m1_q, m2_q;
    logic       gie_q;
    wire        wr_ctl = reg_wr && dir_sel;
    wire  [7:0] src1 = {1'b0, converter_done_flag, 3'h0, ext_pin_flag,
                        input_change_flag, timer8_flag};
    wire  [7:0] src2 = {comparator2_change_flag, 1'b0, timer3_flag, 5'h00};
    // Mirrors of mask writes, so the request can be judged
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m1_q  <= 8'h00;
            m2_q  <= 8'h00;
            gie_q <= 1'b0;
        end else begin
            if (wr_ctl && reg_addr == 4'hF)
                m1_q <= reg_wdata & 8'h47;
            if (wr_ctl && reg_addr == 4'hE)
                m2_q <= reg_wdata & 8'hA0;
            if (global_irq_on_instr)
                gie_q <= 1'b1;
            else if (global_irq_off_instr)
                gie_q <= 1'b0;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_m1_write;
        wr_ctl && reg_addr == 4'hF;
    endsequence
    sequence s_m1_look;
        dir_sel && reg_addr == 4'hF;
    endsequence
    a_pd_follows_reg: assert property (dir_sel && reg_addr == 4'hB |->
        port6_pull_down_en == ~reg_rdata[7:4] && reg_rdata[3:1] == 3'h0
        && port5_pull_down_en == ~reg_rdata[0])
        else $error("pull-down enables disagree with register");
    a_ph_follows_reg: assert property (dir_sel && reg_addr == 4'hD |->
        port6_pull_up_en == ~reg_rdata[5:0] && reg_rdata[7:6] == 2'h0)
        else $error("pull-high enables disagree with register");
    a_od_low_only: assert property (dir_sel && reg_addr == 4'hC |->
        (reg_rdata[5:0] & port6_oe[5:0] & port6_out[5:0]) == 6'h00)
        else $error("open-drain pin drives high");
    a_dir_hiz_in: assert property (dir_sel && reg_addr == 4'h6 |->
        (port6_oe & reg_rdata) == 8'h00)
        else $error("input pin is driven");
    a_m1_read_back: assert property (s_m1_write ##1 s_m1_look |->
        reg_rdata == ($past(reg_wdata) & 8'h47))
        else $error("mask one reads back wrong");
    a_irq_gating: assert property (irq_req == (gie_q && !asleep &&
        |((src1 & m1_q) | (src2 & m2_q))))
        else $error("interrupt request wrong");
    a_sleep_enter: assert property (sleep_instr |=> asleep)
        else $error("sleep not entered");
    a_wake_pulse: assert property ($fell(asleep) |-> ##[0:1] wake_pulse)
        else $error("wake without wake pulse");
    a_wake_target: assert property (wake_pulse |->
        wake_to_vector == (gie_q && m1_q[1]))
        else $error("wake target wrong");
endmodule
bind pwc_top pwc_top_sva pwc_top_sva_inst (.*);

// >>> tb_top.sv
// Bench for pwc_top: registers, pads, masks, change detect, wake.
// Assumes pwc_pins stands for the board on each port.
`timescale 1ns/100ps
module tb_top;
    logic       ref_clk, rst_n, reg_wr, reg_rd, dir_sel, on, off, slp, clr;
    logic       pd5, chg, irq, slpq, wp, wv, e;
    logic [3:0] reg_addr, pd6;
    logic [4:0] flg;
    logic [5:0] pu6;
    logic [7:0] reg_wdata, reg_rdata, rdv, w, x6, p5, p6, p8;
    logic [7:0] x5, x8, en6;
    logic [7:0] o5, e5, o6, e6, o8, e8, mv [0:8];
    logic [7:0] mk [0:8] = '{8'hF1, 8'h3F, 8'h3F, 8'hA0, 8'h47, 8'hFF,
                             8'hFF, 8'hFF, 8'hFF};
    logic [3:0] ad [0:8] = '{4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h5, 4'h6,
                             4'h8, 4'h6};
    int         error_cnt, n_tests, gie, i;
    pwc_top pwc_top_inst (.*, .global_irq_on_instr(on),
        .global_irq_off_instr(off), .sleep_instr(slp), .timer8_flag(flg[0]),
        .ext_pin_flag(flg[1]), .converter_done_flag(flg[2]),
        .comparator2_change_flag(flg[3]), .timer3_flag(flg[4]),
        .input_change_clr(clr), .input_change_flag(chg), .irq_req(irq),
        .irq_vector(), .asleep(slpq), .wake_pulse(wp), .wake_to_vector(wv),
        .port5_in(p5), .port5_out(o5), .port5_oe(e5),
        .port5_pull_down_en(pd5), .port6_in(p6), .port6_out(o6),
        .port6_oe(e6), .port6_pull_up_en(pu6), .port6_pull_down_en(pd6),
        .port8_in(p8), .port8_out(o8), .port8_oe(e8));
    pwc_pins pins5 (.clk({8{ref_clk}}), .oe(e5), .dout(o5), .ext_en(8'hFE),
        .ext_val(x5), .pu(8'h00), .pd({7'h00, pd5}), .pin(p5));
    pwc_pins pins6 (.clk({8{ref_clk}}), .oe(e6), .dout(o6), .ext_en(en6),
        .ext_val(x6), .pu({2'h0, pu6}), .pd({4'h0, pd6}), .pin(p6));
    pwc_pins pins8 (.clk({8{ref_clk}}), .oe(e8), .dout(o8), .ext_en(8'hFF),
        .ext_val(x8), .pu(8'h00), .pd(8'h00), .pin(p8));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [7:0] ex, g);
        n_tests++;
        if (g !== ex) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, ex, g);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One access per two edges: strobes never re-rise in one step
    task automatic acc(input logic wr, s, input logic [3:0] a,
                       input logic [7:0] d);
        {reg_wr, reg_rd, dir_sel, reg_addr, reg_wdata} <= {wr, !wr, s, a, d};
        @(negedge ref_clk);
        rdv = reg_rdata;
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic pulse(input logic [3:0] p);
        {on, off, slp, clr} <= p;
        @(posedge ref_clk);
        {on, off, slp, clr} <= 4'h0;
        @(posedge ref_clk);
    endtask
    task automatic wait_for(input logic wk);
        for (int c = 0; c < 10; c++) begin
            @(negedge ref_clk);
            if ((wk ? wp : chg) === 1'b1)
                return;
        end
        error_cnt++;
        $display("unexpected %s: expected 1, seen 0", wk ? "wake" : "chg");
        report_and_stop();
    endtask
    task automatic check_all();
        logic [7:0] eo;
        for (int j = 0; j < 8; j++) begin
            acc(0, 1, ad[j], 8'h00);
            chk("ctl_reg", mv[j], rdv);
        end
        acc(0, 1, 4'h7, 8'h00);
        chk("unmapped", 8'h00, rdv);
        acc(0, 0, 4'h8, 8'h00);
        chk("p8_read", mv[7] & x8, rdv);
        eo = ~mv[6] & ~({2'h0, mv[1][5:0]} & mv[8]);
        chk("p6_oe", eo, e6);
        chk("p6_drive", mv[8] & eo, o6 & eo);
        chk("p5_oe", ~mv[5], e5);
        chk("p8_oe", ~mv[7], e8);
        chk("pulldn", {~mv[0][7:4], 3'h0, ~mv[0][0]}, {pd6, 3'h0, pd5});
        chk("pullup", {2'h0, ~mv[2][5:0]}, {2'h0, pu6});
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, dir_sel, on, off, slp, clr} = 8'h00;
        {reg_addr, reg_wdata, flg, x6} = 25'h0;
        error_cnt = 0;
        n_tests = 0;
        gie = 0;
        en6 = 8'hFF;
        mv = '{8'hF1, 8'h00, 8'h3F, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
        void'($urandom(32'hC274B28E));
        x6 = 8'($urandom);
        x5 = 8'($urandom);
        x8 = 8'($urandom);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check_all();
        acc(1, 0, 4'h6, 8'h00);
        for (int k = 0; k < 30; k++) begin
            i = $urandom % 9;
            w = 8'($urandom) & (i == 3 ? 8'hBF : i == 4 ? 8'h7F : 8'hFF);
            acc(1, i < 8, ad[i], w);
            mv[i] = w & mk[i];
            check_all();
        end
        acc(1, 1, 4'h6, 8'hFF);
        // Let the synchroniser flush levels from when pins were driven
        repeat (2) @(posedge ref_clk);
        for (int b = 0; b < 8; b++) begin
            acc(0, 0, 4'h6, 8'h00);
            chk("p6_read", x6, rdv);
            pulse(4'h1);
            chk("chg_idle", 8'h00, {7'h0, chg});
            x6[b] <= ~x6[b];
            wait_for(1'b0);
            @(posedge ref_clk);
        end
        acc(0, 0, 4'h6, 8'h00);
        pulse(4'h1);
        for (int k = 0; k < 20; k++) begin
            w = 8'($urandom) & 8'hBF;
            acc(1, 1, 4'hE, w);
            mv[3] = w & 8'hA0;
            w = 8'($urandom) & 8'h7F;
            acc(1, 1, 4'hF, w);
            mv[4] = w & 8'h47;
            flg <= 5'($urandom);
            gie = $urandom % 2;
            pulse(gie ? 4'h8 : 4'h4);
            @(negedge ref_clk);
            e = gie && |(({flg[3], 1'b0, flg[4], 5'h00} & mv[3]) |
                ({1'b0, flg[2], 3'h0, flg[1], 1'b0, flg[0]} & mv[4]));
            chk("irq", {7'h0, e}, {7'h0, irq});
        end
        flg <= 5'h00;
        acc(1, 1, 4'hE, 8'h00);
        acc(1, 0, 4'hA, 8'h40);
        for (int s = 0; s < 3; s++) begin
            acc(1, 1, 4'hF, s > 0 ? 8'h02 : 8'h00);
            acc(0, 0, 4'h6, 8'h00);
            pulse(s == 2 ? 4'h5 : 4'h9);
            pulse(4'h2);
            chk("asleep", 8'h01, {7'h0, slpq});
            x6[0] <= ~x6[0];
            wait_for(1'b1);
            chk("to_vector", {7'h0, s == 1}, {7'h0, wv});
            @(posedge ref_clk);
        end
        report_and_stop();
    end
endmodule
